//--- verilog/vdm_pkg.sv
// Constants and carrier types shared by the voice and data frame multiplexer.
`default_nettype none

package vdm_pkg;

  // ==========================================================================
  // Frame geometry
  // ==========================================================================
  localparam int unsigned FRAME_BYTES = 144;  // Bytes in one core frame.
  localparam int unsigned SUB_BYTES   = 36;   // Bytes in one sub-block.
  localparam int unsigned SUB_COUNT   = 4;    // Sub-blocks per frame.
  localparam int unsigned DATA_BYTES  = 128;  // Data bytes per frame.
  localparam int unsigned OVH_BYTES   = 16;   // Non-data bytes per frame.
  localparam int unsigned CH_COUNT    = 3;    // Telephone channels.

  localparam int unsigned SLOT_W = 8;         // Width of the frame position.
  localparam int unsigned IDX_W  = 6;         // Width of sub-block position.
  localparam int unsigned SUB_W  = 2;         // Width of sub-block number.
  localparam int unsigned SEL_W  = 2;         // Width of a channel select.

  // Positions inside each sub-block, counted from zero, and the sync sub-block number.
  localparam logic [IDX_W-1:0] IDX_CH1        = 6'h00;
  localparam logic [IDX_W-1:0] IDX_CH2        = 6'h01;
  localparam logic [IDX_W-1:0] IDX_DATA_FIRST = 6'h02;
  localparam logic [IDX_W-1:0] IDX_DATA_LAST  = 6'h21;
  localparam logic [IDX_W-1:0] IDX_CH3        = 6'h22;
  localparam logic [IDX_W-1:0] IDX_OVH        = 6'h23;
  localparam logic [SUB_W-1:0] SUB_SYNC       = 2'h3;

  // ==========================================================================
  // Fixed content
  // ==========================================================================
  localparam logic [6:0] SYNC_WORD = 7'h72;   // Pattern 1110010.
  localparam logic       STUFF_BIT = 1'h0;    // First bit of the last byte.
  localparam logic [7:0] FILL_BYTE = 8'hff;   // Data sent while out of service.
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] ZERO_NIB  = 4'h0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned FRAME_PERIOD_US = 500;
  localparam int unsigned SUB_PERIOD_US   = 125;
  localparam int unsigned MAX_DELAY_US    = 1250;
  localparam int unsigned FRAME_CYC = FRAME_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SUB_CYC   = SUB_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LOSS_CYC  = FRAME_CYC + SUB_CYC;
  localparam int unsigned GAP_W     = 16;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [7:0] sample;                       // Companded voice byte.
    logic [3:0] sig;                          // Signalling nibble.
  } vdm_voice_t;

  typedef struct packed {
    logic power_status_bit_one;
    logic power_status_bit_two;
  } vdm_pwr_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_LOCK = 2'b10
  } vdm_rx_state_t;

endpackage

`default_nettype wire

//--- verilog/vdm_slot_counter.sv
// Frame position counter giving slot, sub-block and position in sub-block.
`timescale 1ns/1ns
`default_nettype none

module vdm_slot_counter #(
  parameter int unsigned FRAME_LEN = vdm_pkg::FRAME_BYTES,
  parameter int unsigned SUB_LEN   = vdm_pkg::SUB_BYTES
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       step,
  input  wire logic                       restart,
  output logic [vdm_pkg::SLOT_W-1:0]      slot,
  output logic [vdm_pkg::IDX_W-1:0]       idx,
  output logic [vdm_pkg::SUB_W-1:0]       sub,
  output logic                            last
);
  import vdm_pkg::*;

  localparam logic [SLOT_W-1:0] SLOT_END = SLOT_W'(FRAME_LEN - 1);
  localparam logic [IDX_W-1:0]  IDX_END  = IDX_W'(SUB_LEN - 1);

  logic [SLOT_W-1:0] slot_ff;
  logic [SLOT_W-1:0] nxt_slot_ff;
  logic [IDX_W-1:0]  idx_ff;
  logic [IDX_W-1:0]  nxt_idx_ff;
  logic [SUB_W-1:0]  sub_ff;
  logic [SUB_W-1:0]  nxt_sub_ff;

  // The current position; a restart makes the present byte the first one.
  always_comb begin
    slot = restart ? '0 : slot_ff;
    idx  = restart ? '0 : idx_ff;
    sub  = restart ? '0 : sub_ff;
    last = (slot == SLOT_END);
  end

  // Advance by one byte on each step and wrap at the frame end.
  always_comb begin
    nxt_slot_ff = slot_ff;
    nxt_idx_ff  = idx_ff;
    nxt_sub_ff  = sub_ff;
    if (step) begin
      nxt_slot_ff = last ? '0 : SLOT_W'(slot + 1'b1);
      nxt_idx_ff  = (idx == IDX_END) ? '0 : IDX_W'(idx + 1'b1);
      if (last) begin
        nxt_sub_ff = '0;
      end else if (idx == IDX_END) begin
        nxt_sub_ff = SUB_W'(sub + 1'b1);
      end else begin
        nxt_sub_ff = sub;
      end
    end
  end

  // Position registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      slot_ff <= '0;
      idx_ff  <= '0;
      sub_ff  <= '0;
    end else begin
      slot_ff <= nxt_slot_ff;
      idx_ff  <= nxt_idx_ff;
      sub_ff  <= nxt_sub_ff;
    end
  end

endmodule

`default_nettype wire

//--- verilog/vdm_frame_mux.sv
// Core frame multiplexer and demultiplexer for data plus three voice lines.
//
// How it works
// - Send one 144-byte frame per 500 us; accept received frames alike.
// - Exactly 128 byte positions per frame carry the 2048 kbit/s data.
// - Sixteen other bytes carry sync, twelve voice bytes, signalling, spare.
// - Voice, signalling and spare blocks always sit at fixed positions.
// - Each voice channel carries one companded byte every 125 us.
// - Each channel sends one 4-bit signalling nibble per frame, 8 kbit/s.
// - Voice byte and signalling together form a 72 kbit/s channel stream.
// - Up to three telephone channels travel beside the data signal.
// - Data bytes are mapped regardless of their value.
// - Bits 2 to 8 of the last byte carry sync pattern 1110010.
// - First bit of the last byte is sent zero and ignored on receive.
// - Each channel has its own signalling nibble sharing a byte with spare.
// - Voice conversion timing comes from the core frame byte timing.
// - Frame timing follows the data interface clock; no justification.
// - One-way delay stays well below 1250 us; one byte of buffering.
// - Local power loss goes out on both status bits; receive drives bypass.
// - Under bypass only telephone channels work; data is out of service.
// - A maintenance port reads and writes the spare capacity nibbles.
`timescale 1ns/1ns
`default_nettype none

module vdm_frame_mux #(
  parameter int unsigned LOSS_LIMIT = vdm_pkg::LOSS_CYC
) (
  input  wire logic                                   clk,
  input  wire logic                                   reset,
  // Transmit side: data interface, converters and line side.
  input  wire logic                                   tx_byte_en,
  input  wire logic [7:0]                             tx_data_in,
  output logic                                        tx_data_take,
  input  wire vdm_pkg::vdm_voice_t [vdm_pkg::CH_COUNT-1:0] tx_voice_in,
  output logic                                        tx_voice_tick,
  output logic [7:0]                                  tx_byte,
  output logic                                        tx_byte_valid,
  output logic                                        tx_frame_start,
  // Power status and bypass.
  input  wire logic                                   local_power_fail,
  output vdm_pkg::vdm_pwr_t                           tx_power_status,
  input  wire vdm_pkg::vdm_pwr_t                      rx_power_status,
  output logic                                        bypass_active,
  output logic                                        data_out_of_service,
  // Receive side: line side, data interface and converters.
  input  wire logic                                   rx_byte_en,
  input  wire logic [7:0]                             rx_byte,
  input  wire logic                                   rx_frame_start,
  output logic [7:0]                                  rx_data,
  output logic                                        rx_data_valid,
  output vdm_pkg::vdm_voice_t [vdm_pkg::CH_COUNT-1:0] rx_voice,
  output logic                                        rx_voice_tick,
  output logic                                        rx_sync_error,
  output logic                                        rx_frame_lost,
  // Maintenance access to the spare capacity nibbles.
  input  wire logic                                   mnt_wr,
  input  wire logic                                   mnt_rd,
  input  wire logic [vdm_pkg::SEL_W-1:0]              mnt_sel,
  input  wire logic [3:0]                             mnt_wdata,
  output logic [7:0]                                  mnt_rdata
);
  import vdm_pkg::*;

  localparam logic [GAP_W-1:0] GAP_END = GAP_W'(LOSS_LIMIT - 1);
  localparam logic [SUB_W-1:0] CH_LAST = SUB_W'(CH_COUNT - 1);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [SLOT_W-1:0]          tx_slot;
  logic [IDX_W-1:0]           tx_idx;
  logic [SUB_W-1:0]           tx_sub;
  logic                       tx_last;
  logic [SLOT_W-1:0]          rx_slot;
  logic [IDX_W-1:0]           rx_idx;
  logic [SUB_W-1:0]           rx_sub;
  logic                       rx_last;
  logic                       rx_step;
  logic                       rx_restart;
  logic                       tx_is_data;
  logic                       rx_is_data;
  logic                       oos;

  logic [7:0]                 tx_byte_ff;
  logic [7:0]                 nxt_tx_byte_ff;
  logic                       tx_valid_ff;
  logic                       nxt_tx_valid_ff;
  logic                       tx_start_ff;
  logic                       nxt_tx_start_ff;
  vdm_voice_t [CH_COUNT-1:0]  tx_hold_ff;
  vdm_voice_t [CH_COUNT-1:0]  nxt_tx_hold_ff;

  vdm_pwr_t                   pwr_ff;
  vdm_pwr_t                   nxt_pwr_ff;
  logic                       bypass_ff;
  logic                       nxt_bypass_ff;

  vdm_rx_state_t              rx_state_ff;
  vdm_rx_state_t              nxt_rx_state_ff;
  logic [GAP_W-1:0]           gap_ff;
  logic [GAP_W-1:0]           nxt_gap_ff;
  logic                       lost_ff;
  logic                       nxt_lost_ff;
  logic [7:0]                 rx_data_ff;
  logic [7:0]                 nxt_rx_data_ff;
  logic                       rx_valid_ff;
  logic                       nxt_rx_valid_ff;
  vdm_voice_t [CH_COUNT-1:0]  rx_voice_ff;
  vdm_voice_t [CH_COUNT-1:0]  nxt_rx_voice_ff;
  logic                       rx_tick_ff;
  logic                       nxt_rx_tick_ff;
  logic                       sync_err_ff;
  logic                       nxt_sync_err_ff;

  logic [CH_COUNT-1:0][3:0]   tx_z_ff;
  logic [CH_COUNT-1:0][3:0]   nxt_tx_z_ff;
  logic [CH_COUNT-1:0][3:0]   rx_z_ff;
  logic [CH_COUNT-1:0][3:0]   nxt_rx_z_ff;
  logic [7:0]                 mnt_rdata_ff;
  logic [7:0]                 nxt_mnt_rdata_ff;

  // ==========================================================================
  // Frame position counters
  // ==========================================================================
  // Transmit position advances on every byte slot of the core frame timing,
  // which the line side derives from the data interface clock.
  vdm_slot_counter #(
    .FRAME_LEN (FRAME_BYTES),
    .SUB_LEN   (SUB_BYTES)
  ) u_tx_pos (
    .clk     (clk),
    .reset   (reset),
    .step    (tx_byte_en),
    .restart (1'b0),
    .slot    (tx_slot),
    .idx     (tx_idx),
    .sub     (tx_sub),
    .last    (tx_last)
  );

  // Receive position is forced to the first byte on each frame start mark.
  assign rx_restart = rx_byte_en & rx_frame_start;
  assign rx_step    = rx_byte_en & ((rx_state_ff == RX_LOCK) | rx_frame_start);

  vdm_slot_counter #(
    .FRAME_LEN (FRAME_BYTES),
    .SUB_LEN   (SUB_BYTES)
  ) u_rx_pos (
    .clk     (clk),
    .reset   (reset),
    .step    (rx_step),
    .restart (rx_restart),
    .slot    (rx_slot),
    .idx     (rx_idx),
    .sub     (rx_sub),
    .last    (rx_last)
  );

  // Data positions are the 32 middle bytes of each sub-block.
  assign tx_is_data = (tx_idx >= IDX_DATA_FIRST) & (tx_idx <= IDX_DATA_LAST);
  assign rx_is_data = (rx_idx >= IDX_DATA_FIRST) & (rx_idx <= IDX_DATA_LAST);

  // ==========================================================================
  // Power status and bypass
  // ==========================================================================
  // Data goes out of service on local power loss or a far-end loss report.
  assign oos = local_power_fail | bypass_ff;

  always_comb begin
    nxt_pwr_ff.power_status_bit_one = local_power_fail;
    nxt_pwr_ff.power_status_bit_two = local_power_fail;
    nxt_bypass_ff = rx_power_status.power_status_bit_one &
                    rx_power_status.power_status_bit_two;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwr_ff    <= '0;
      bypass_ff <= 1'b0;
    end else begin
      pwr_ff    <= nxt_pwr_ff;
      bypass_ff <= nxt_bypass_ff;
    end
  end

  // ==========================================================================
  // Transmit multiplexer
  // ==========================================================================
  // The data source is pulled only in data slots and never under bypass.
  assign tx_data_take  = tx_byte_en & tx_is_data & ~oos;
  // Converters present the next sample after each sub-block ends.
  assign tx_voice_tick = tx_byte_en & (tx_idx == IDX_OVH);

  // Select the byte for the present slot and refresh the held samples.
  always_comb begin
    nxt_tx_byte_ff  = tx_byte_ff;
    nxt_tx_valid_ff = 1'b0;
    nxt_tx_start_ff = 1'b0;
    nxt_tx_hold_ff  = tx_hold_ff;
    if (tx_byte_en) begin
      nxt_tx_valid_ff = 1'b1;
      nxt_tx_start_ff = (tx_slot == '0);
      case (tx_idx)
        IDX_CH1: nxt_tx_byte_ff = tx_hold_ff[0].sample;
        IDX_CH2: nxt_tx_byte_ff = tx_hold_ff[1].sample;
        IDX_CH3: nxt_tx_byte_ff = tx_hold_ff[2].sample;
        IDX_OVH: begin
          if (tx_sub == SUB_SYNC) begin
            nxt_tx_byte_ff = {STUFF_BIT, SYNC_WORD};
          end else begin
            nxt_tx_byte_ff = {tx_hold_ff[tx_sub].sig,
                              tx_z_ff[tx_sub]};
          end
        end
        default: begin
          // Data is passed as it comes, whatever the bit pattern.
          nxt_tx_byte_ff = oos ? FILL_BYTE : tx_data_in;
        end
      endcase
      // New samples are taken once per sub-block, after channel 3 is sent.
      if (tx_idx == IDX_OVH) begin
        for (int k = 0; k < CH_COUNT; k++) begin
          nxt_tx_hold_ff[k].sample = tx_voice_in[k].sample;
        end
      end
      // Signalling nibbles are taken once per frame, at its last byte.
      if (tx_last) begin
        for (int k = 0; k < CH_COUNT; k++) begin
          nxt_tx_hold_ff[k].sig = tx_voice_in[k].sig;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_byte_ff  <= ZERO_BYTE;
      tx_valid_ff <= 1'b0;
      tx_start_ff <= 1'b0;
      tx_hold_ff  <= '0;
    end else begin
      tx_byte_ff  <= nxt_tx_byte_ff;
      tx_valid_ff <= nxt_tx_valid_ff;
      tx_start_ff <= nxt_tx_start_ff;
      tx_hold_ff  <= nxt_tx_hold_ff;
    end
  end

  // ==========================================================================
  // Receive alignment and frame watchdog
  // ==========================================================================
  // Hunt until a frame start mark, then declare loss if none follows in time.
  always_comb begin
    nxt_rx_state_ff = rx_state_ff;
    nxt_gap_ff      = gap_ff;
    nxt_lost_ff     = lost_ff;
    case (rx_state_ff)
      RX_HUNT: begin
        nxt_gap_ff = '0;
        if (rx_restart) begin
          nxt_rx_state_ff = RX_LOCK;
          nxt_lost_ff     = 1'b0;
        end
      end
      RX_LOCK: begin
        if (rx_restart) begin
          nxt_gap_ff  = '0;
          nxt_lost_ff = 1'b0;
        end else if (gap_ff == GAP_END) begin
          nxt_rx_state_ff = RX_HUNT;
          nxt_lost_ff     = 1'b1;
        end else begin
          nxt_gap_ff = GAP_W'(gap_ff + 1'b1);
        end
      end
      default: begin
        nxt_rx_state_ff = RX_HUNT;
        nxt_gap_ff      = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state_ff <= RX_HUNT;
      gap_ff      <= '0;
      lost_ff     <= 1'b0;
    end else begin
      rx_state_ff <= nxt_rx_state_ff;
      gap_ff      <= nxt_gap_ff;
      lost_ff     <= nxt_lost_ff;
    end
  end

  // ==========================================================================
  // Receive demultiplexer
  // ==========================================================================
  // Split each accepted byte by its fixed position in the frame.
  always_comb begin
    nxt_rx_data_ff  = rx_data_ff;
    nxt_rx_valid_ff = 1'b0;
    nxt_rx_voice_ff = rx_voice_ff;
    nxt_rx_tick_ff  = 1'b0;
    nxt_sync_err_ff = sync_err_ff;
    nxt_rx_z_ff     = rx_z_ff;
    if (rx_step) begin
      case (rx_idx)
        IDX_CH1: nxt_rx_voice_ff[0].sample = rx_byte;
        IDX_CH2: nxt_rx_voice_ff[1].sample = rx_byte;
        IDX_CH3: nxt_rx_voice_ff[2].sample = rx_byte;
        IDX_OVH: begin
          nxt_rx_tick_ff = 1'b1;
          if (rx_sub == SUB_SYNC) begin
            // The stuffing bit is not looked at.
            nxt_sync_err_ff = (rx_byte[6:0] != SYNC_WORD);
          end else begin
            nxt_rx_voice_ff[rx_sub].sig = rx_byte[7:4];
            nxt_rx_z_ff[rx_sub]         = rx_byte[3:0];
          end
        end
        default: begin
          nxt_rx_data_ff  = rx_byte;
          nxt_rx_valid_ff = ~oos;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_data_ff  <= ZERO_BYTE;
      rx_valid_ff <= 1'b0;
      rx_voice_ff <= '0;
      rx_tick_ff  <= 1'b0;
      sync_err_ff <= 1'b0;
      rx_z_ff     <= '0;
    end else begin
      rx_data_ff  <= nxt_rx_data_ff;
      rx_valid_ff <= nxt_rx_valid_ff;
      rx_voice_ff <= nxt_rx_voice_ff;
      rx_tick_ff  <= nxt_rx_tick_ff;
      sync_err_ff <= nxt_sync_err_ff;
      rx_z_ff     <= nxt_rx_z_ff;
    end
  end

  // ==========================================================================
  // Maintenance access to spare capacity
  // ==========================================================================
  // Writes set a transmit nibble; reads return received and sent nibbles.
  always_comb begin
    nxt_tx_z_ff      = tx_z_ff;
    nxt_mnt_rdata_ff = mnt_rdata_ff;
    if (mnt_wr && (mnt_sel <= CH_LAST)) begin
      nxt_tx_z_ff[mnt_sel] = mnt_wdata;
    end
    if (mnt_rd) begin
      if (mnt_sel <= CH_LAST) begin
        nxt_mnt_rdata_ff = {rx_z_ff[mnt_sel], tx_z_ff[mnt_sel]};
      end else begin
        nxt_mnt_rdata_ff = {ZERO_NIB, ZERO_NIB};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_z_ff      <= '0;
      mnt_rdata_ff <= ZERO_BYTE;
    end else begin
      tx_z_ff      <= nxt_tx_z_ff;
      mnt_rdata_ff <= nxt_mnt_rdata_ff;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Only one register stage lies between input and output bytes.
  assign tx_byte             = tx_byte_ff;
  assign tx_byte_valid       = tx_valid_ff;
  assign tx_frame_start      = tx_start_ff;
  assign tx_power_status     = pwr_ff;
  assign bypass_active       = bypass_ff;
  assign data_out_of_service = oos;
  assign rx_data             = rx_data_ff;
  assign rx_data_valid       = rx_valid_ff;
  assign rx_voice            = rx_voice_ff;
  assign rx_voice_tick       = rx_tick_ff;
  assign rx_sync_error       = sync_err_ff;
  assign rx_frame_lost       = lost_ff;
  assign mnt_rdata           = mnt_rdata_ff;

endmodule

`default_nettype wire

//--- bench/vdm_chk.sv
// Port checker for the core frame multiplexer.
`timescale 1ns/1ns
`default_nettype none
module vdm_chk
  import vdm_pkg::*;
#(
  parameter int unsigned LOSS_LIMIT = 6250
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       tx_byte_en,
  input wire logic       tx_data_take,
  input wire logic       tx_voice_tick,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_byte_valid,
  input wire logic       tx_frame_start,
  input wire logic       local_power_fail,
  input wire vdm_pwr_t   tx_power_status,
  input wire vdm_pwr_t   rx_power_status,
  input wire logic       bypass_active,
  input wire logic       data_out_of_service,
  input wire logic       mnt_rd,
  input wire logic [1:0] mnt_sel,
  input wire logic [7:0] mnt_rdata
);
  logic [7:0] pos_ff;
  logic [7:0] nxt_pos;
  logic [5:0] idx;
  logic       dat;
  // Tracks the slot that the next byte enable fills.
  always_comb begin
    nxt_pos = pos_ff;
    if (tx_byte_en) nxt_pos = (pos_ff == 8'h8f) ? 8'h00 : pos_ff + 8'h01;
  end
  always_ff @(posedge clk) pos_ff <= reset ? 8'h00 : nxt_pos;
  assign idx = 6'(pos_ff % 8'h24);
  assign dat = idx > 6'h01 && idx < 6'h22;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  take_slot_a: assert property (
    tx_data_take == (tx_byte_en && dat && !data_out_of_service))
    else $error("data take off slot");
  voice_tick_a: assert property (
    tx_voice_tick == (tx_byte_en && idx == 6'h23)) else $error("voice tick");
  frame_start_a: assert property (
    tx_byte_valid |-> tx_frame_start == (pos_ff == 8'h01))
    else $error("frame start");
  sync_word_a: assert property (
    tx_byte_en && pos_ff == 8'h8f |=> tx_byte == 8'h72) else $error("sync");
  data_fill_a: assert property (
    tx_byte_en && dat && !tx_data_take |=> tx_byte == 8'hff)
    else $error("fill byte");
  power_copy_a: assert property (
    tx_power_status == {2{$past(local_power_fail)}}) else $error("power bits");
  bypass_ctl_a: assert property (
    bypass_active == ($past(rx_power_status) == 2'h3)) else $error("bypass");
  mnt_none_a: assert property (
    mnt_rd && mnt_sel == 2'h3 |=> mnt_rdata == 8'h00) else $error("mnt none");
endmodule
bind vdm_frame_mux vdm_chk #(.LOSS_LIMIT(LOSS_LIMIT)) u_vdm_chk (.clk, .reset,
  .tx_byte_en, .tx_data_take, .tx_voice_tick, .tx_byte, .tx_byte_valid,
  .tx_frame_start, .local_power_fail, .tx_power_status, .rx_power_status,
  .bypass_active, .data_out_of_service, .mnt_rd, .mnt_sel, .mnt_rdata);
`default_nettype wire

//--- bench/vdm_line_model.sv
// Line side model that hands each sent core frame straight back.
`timescale 1ns/1ns
`default_nettype none
module vdm_line_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_byte_valid,
  input  wire logic       tx_frame_start,
  output logic            rx_byte_en,
  output logic [7:0]      rx_byte,
  output logic            rx_frame_start
);
  // Bytes return unchanged; between bytes the line inverts its value on every clock.
  always_ff @(posedge clk) begin
    rx_byte_en     <= !reset && tx_byte_valid;
    rx_frame_start <= !reset && tx_frame_start;
    rx_byte        <= tx_byte_valid ? tx_byte : ~rx_byte;
  end
endmodule
`default_nettype wire

//--- bench/vdm_frame_mux_tb.sv
// Self-checking bench for the core frame multiplexer.
`timescale 1ns/1ns
`default_nettype none
module vdm_frame_mux_tb;
  import vdm_pkg::*;
  logic             clk = 1'b0, reset = 1'b1, tx_byte_en = 1'b0;
  logic             local_power_fail = 1'b0, mnt_wr = 1'b0, mnt_rd = 1'b0;
  logic [1:0]       mnt_sel = 2'h0;
  logic [3:0]       mnt_wdata = 4'h0;
  logic [7:0]       tx_data_in = 8'h00, pos = 8'h00;
  vdm_voice_t [2:0] tx_voice_in = '0, hold_s = '0, hold_g = '0, rx_voice;
  vdm_pwr_t         rx_power_status = '0, tx_power_status;
  logic [7:0]       tx_byte, rx_byte, rx_data, mnt_rdata;
  logic             tx_data_take, tx_voice_tick, tx_byte_valid, tx_frame_start;
  logic             bypass_active, data_out_of_service, rx_byte_en;
  logic             rx_frame_start, rx_data_valid, rx_voice_tick;
  logic             rx_sync_error, rx_frame_lost;
  logic [3:0]       z [3];
  logic [8:0]       txq [$], rxq [$];
  logic [23:0]      vq [$];
  int               seed = 32'hc17653d1, error_cnt = 0, n_tests = 0;
  vdm_frame_mux u_vdm_frame_mux (.clk, .reset, .tx_byte_en, .tx_data_in,
    .tx_data_take, .tx_voice_in, .tx_voice_tick, .tx_byte, .tx_byte_valid,
    .tx_frame_start, .local_power_fail, .tx_power_status, .rx_power_status,
    .bypass_active, .data_out_of_service, .rx_byte_en, .rx_byte,
    .rx_frame_start, .rx_data, .rx_data_valid, .rx_voice, .rx_voice_tick,
    .rx_sync_error, .rx_frame_lost, .mnt_wr, .mnt_rd, .mnt_sel, .mnt_wdata,
    .mnt_rdata);
  vdm_line_model u_vdm_line_model (.clk, .reset, .tx_byte, .tx_byte_valid,
    .tx_frame_start, .rx_byte_en, .rx_byte, .rx_frame_start);
  always #50 clk = ~clk;
  task automatic cmp(string n, logic [23:0] e, logic [23:0] s);
    n_tests++;
    if (e !== s) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Sends one slot and notes the byte the frame layout puts there.
  task automatic send_byte();
    logic [5:0] i;
    logic [7:0] e;
    logic       oos;
    i = 6'(pos % 8'h24);
    oos = local_power_fail || (rx_power_status == 2'h3);
    if (i == 6'h00) tx_voice_in = 36'({$random(seed), $random(seed)});
    tx_data_in = 8'($random(seed));
    if (i < 6'h02) e = hold_s[i].sample;
    else if (i < 6'h22) e = oos ? 8'hff : tx_data_in;
    else if (i == 6'h22) e = hold_s[2].sample;
    else if (pos == 8'h8f) e = 8'h72;
    else e = {hold_g[pos / 8'h24].sig, z[pos / 8'h24]};
    txq.push_back({pos == 8'h00, e});
    if (i > 6'h01 && i < 6'h22 && !oos) rxq.push_back({1'b0, e});
    if (i == 6'h23) begin
      vq.push_back({hold_s[2].sample, hold_s[1].sample, hold_s[0].sample});
      hold_s = tx_voice_in;
    end
    if (pos == 8'h8f) hold_g = tx_voice_in;
    pos = (pos == 8'h8f) ? 8'h00 : pos + 8'h01;
    tx_byte_en = 1'b1;
    @(negedge clk) tx_byte_en = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic mnt(logic wr, logic [1:0] s, logic [3:0] d, logic [8:0] e);
    {mnt_wr, mnt_rd, mnt_sel, mnt_wdata} = {wr, !wr, s, d};
    @(negedge clk) {mnt_wr, mnt_rd} = 2'b00;
    if (!wr) cmp("mnt_rdata", e, {1'b0, mnt_rdata});
    @(negedge clk);
  endtask
  // Each result takes the oldest expectation noted for it.
  always @(negedge clk) begin
    if (tx_byte_valid) cmp("tx_byte", txq.size() ? txq.pop_front() : 'x,
      {tx_frame_start, tx_byte});
    if (rx_data_valid) cmp("rx_data", rxq.size() ? rxq.pop_front() : 'x,
      {1'b0, rx_data});
    if (rx_voice_tick) cmp("rx_voice", vq.size() ? vq.pop_front() : 'x,
      {rx_voice[2].sample, rx_voice[1].sample, rx_voice[0].sample});
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (k < 3) z[k] = 4'($random(seed));
      mnt(1'b1, 2'(k), (k < 3) ? z[k] : 4'hf, 9'h000);
    end
    for (int f = 0; f < 6; f++) begin
      local_power_fail = (f == 3);
      rx_power_status = (f == 4) ? 2'h3 : 2'(f);
      repeat (5) @(negedge clk);
      repeat (144) send_byte();
    end
    repeat (8) @(negedge clk);
    for (int k = 0; k < 4; k++)
      mnt(1'b0, 2'(k), 4'h0, (k < 3) ? {1'b0, z[k], z[k]} : 9'h000);
    cmp("rx_flags", 9'h000, {7'h00, rx_frame_lost, rx_sync_error});
    cmp("queues", 9'h000, 9'(txq.size() + rxq.size() + vq.size()));
    // With no more frame marks the watchdog must declare the frame lost.
    repeat (LOSS_CYC) @(negedge clk);
    cmp("rx_lost", 9'h002, {7'h00, rx_frame_lost, rx_sync_error});
    give_verdict();
  end
endmodule
`default_nettype wire
